// ### hw/osc_ctrl_map.vh
// Register map, field positions and reset values of the oscillator control block
`ifndef OSC_CTRL_MAP_VH
`define OSC_CTRL_MAP_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define OSC_CTRL_ADDR 8'h25
`define FUNCTION_ADDR 8'h28
`define PIN_A_IRQ_ADDR 8'h29
`define PIN_B_IRQ_ADDR 8'h2A

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OUTPUT_INVERSION_BIT 7
`define OFFSET_MODE_BIT 6
`define HOUR_FORMAT_BIT 5
`define LOW_JITTER_BIT 4
`define DRIVE_HI 3
`define DRIVE_LO 2
`define LOAD_CAP_HI 1
`define LOAD_CAP_LO 0
`define CLKOUT_FREQ_HI 2
`define CLKOUT_FREQ_LO 0

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define OSC_CTRL_RESET 8'h00
`define FUNCTION_RESET 8'h00
`define IRQ_MASK_RESET 8'h00
`define DRIVE_NORMAL 2'h0
`define DRIVE_LOW 2'h1
`define DRIVE_HIGH 2'h2
`define CAP_7P0 2'h0
`define CAP_6P0 2'h1
`define CAP_12P5 2'h2

`endif

// ### hw/osc_ctrl_regs.v
// Oscillator control register with clock output inversion and per-pin interrupt routing
//
// Operation
// - Eight-bit oscillator control register at 25h
// - Bit 7 inverts clock output; default off
// - Inversion acts on selected output frequency
// - Low jitter bit; default normal behaviour
// - Bit 5 selects 12-hour; default 24-hour
// - Hour format ignored in stop-watch mode
// - Drive field: normal, low, high, high
// - Capacitance field: 7.0, 6.0, 12.5, 12.5 pF
// - Bit 6 selects offset calibration mode
// - Masks at 29h/2Ah route sources per pin
`timescale 1ns/1ns
`include "osc_ctrl_map.vh"

module osc_ctrl_regs
(
	input wire core_clk,
	input wire reset_n,
	input wire clk_en,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire stopwatch_mode,
	input wire [7:0] clkout_taps,
	input wire [6:0] irq_sources,
	output reg [7:0] reg_rdata,
	output reg clk_out,
	output reg low_jitter_rise,
	output reg low_jitter_fall,
	output reg offset_mode,
	output reg twelve_hour,
	output reg [1:0] drive_level,
	output reg [1:0] load_cap,
	output reg irq_a,
	output reg irq_b
);

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	reg [7:0] osc_ctrl_q;
	reg [7:0] function_q;
	reg [7:0] pin_a_irq_mask_q;
	reg [7:0] pin_b_irq_mask_q;
	reg [7:0] rdata_d;
	reg [7:0] taps_meta_q;
	reg [7:0] taps_q;
	reg stopwatch_meta_q;
	reg stopwatch_q;
	reg [6:0] src_meta_q;
	reg [6:0] src_q;
	wire sel_clk;
	wire inv;

	always @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			osc_ctrl_q <= `OSC_CTRL_RESET;
			function_q <= `FUNCTION_RESET;
			pin_a_irq_mask_q <= `IRQ_MASK_RESET;
			pin_b_irq_mask_q <= `IRQ_MASK_RESET;
		end
		else if (clk_en && reg_wr)
		begin
			case (reg_addr)
				`OSC_CTRL_ADDR: osc_ctrl_q <= reg_wdata;
				`FUNCTION_ADDR: function_q <= reg_wdata;
				`PIN_A_IRQ_ADDR: pin_a_irq_mask_q <= reg_wdata;
				`PIN_B_IRQ_ADDR: pin_b_irq_mask_q <= reg_wdata;
				default: osc_ctrl_q <= osc_ctrl_q;
			endcase
		end
	end

	// Unmapped addresses read as zero
	always @*
	begin
		case (reg_addr)
			`OSC_CTRL_ADDR: rdata_d = osc_ctrl_q;
			`FUNCTION_ADDR: rdata_d = function_q;
			`PIN_A_IRQ_ADDR: rdata_d = pin_a_irq_mask_q;
			`PIN_B_IRQ_ADDR: rdata_d = pin_b_irq_mask_q;
			default: rdata_d = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Candidate clocks come from the timebase divider, not from core_clk logic
	always @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			taps_meta_q <= 8'h00;
			taps_q <= 8'h00;
		end
		else if (clk_en)
		begin
			taps_meta_q <= clkout_taps;
			taps_q <= taps_meta_q;
		end
	end

	// Mode level changes rarely; two stages are enough against metastability
	always @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			stopwatch_meta_q <= 1'b0;
			stopwatch_q <= 1'b0;
		end
		else if (clk_en)
		begin
			stopwatch_meta_q <= stopwatch_mode;
			stopwatch_q <= stopwatch_meta_q;
		end
	end

	// Sources are levels; a pulse shorter than one cycle may be missed
	always @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			src_meta_q <= 7'h00;
			src_q <= 7'h00;
		end
		else if (clk_en)
		begin
			src_meta_q <= irq_sources;
			src_q <= src_meta_q;
		end
	end

	// ----------------------------------------
	// Field decode
	// ----------------------------------------
	wire low_jitter_bit;
	wire offset_bit;
	wire hour_bit;
	wire [1:0] drive_field;
	wire [1:0] cap_field;
	wire [2:0] freq_sel;
	wire [1:0] drive_d;
	wire [1:0] cap_d;
	wire twelve_hour_d;
	wire low_jitter_rise_d;
	wire low_jitter_fall_d;
	wire clk_out_d;

	assign inv = osc_ctrl_q[`OUTPUT_INVERSION_BIT];
	assign offset_bit = osc_ctrl_q[`OFFSET_MODE_BIT];
	assign hour_bit = osc_ctrl_q[`HOUR_FORMAT_BIT];
	assign low_jitter_bit = osc_ctrl_q[`LOW_JITTER_BIT];
	assign drive_field = osc_ctrl_q[`DRIVE_HI:`DRIVE_LO];
	assign cap_field = osc_ctrl_q[`LOAD_CAP_HI:`LOAD_CAP_LO];
	assign freq_sel = function_q[`CLKOUT_FREQ_HI:`CLKOUT_FREQ_LO];

	// Both upper drive codes share the high drive
	assign drive_d = drive_field[1] ? `DRIVE_HIGH : drive_field;
	// Both upper capacitance codes share 12.5 pF
	assign cap_d = cap_field[1] ? `CAP_12P5 : cap_field;
	// Stop-watch counting has no meridiem, so the format bit is masked
	assign twelve_hour_d = hour_bit & ~stopwatch_q;
	// The low jitter edge follows the inversion onto the falling edge
	assign low_jitter_rise_d = low_jitter_bit & ~inv;
	assign low_jitter_fall_d = low_jitter_bit & inv;
	assign sel_clk = taps_q[freq_sel];
	assign clk_out_d = sel_clk ^ inv;

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Held between reads so that a slow host may sample it late
	always @(posedge core_clk)
	begin
		if (!reset_n)
			reg_rdata <= 8'h00;
		else if (clk_en && reg_rd)
			reg_rdata <= rdata_d;
	end

	// ----------------------------------------
	// Clock output
	// ----------------------------------------
	// Registered tap adds one cycle of delay but keeps the pin glitch free
	always @(posedge core_clk)
	begin
		if (!reset_n)
			clk_out <= 1'b0;
		else if (clk_en)
			clk_out <= clk_out_d;
	end

	always @(posedge core_clk)
	begin
		if (!reset_n)
			low_jitter_rise <= 1'b0;
		else if (clk_en)
			low_jitter_rise <= low_jitter_rise_d;
	end

	always @(posedge core_clk)
	begin
		if (!reset_n)
			low_jitter_fall <= 1'b0;
		else if (clk_en)
			low_jitter_fall <= low_jitter_fall_d;
	end

	// ----------------------------------------
	// Oscillator and calendar settings
	// ----------------------------------------
	always @(posedge core_clk)
	begin
		if (!reset_n)
			offset_mode <= 1'b0;
		else if (clk_en)
			offset_mode <= offset_bit;
	end

	always @(posedge core_clk)
	begin
		if (!reset_n)
			twelve_hour <= 1'b0;
		else if (clk_en)
			twelve_hour <= twelve_hour_d;
	end

	always @(posedge core_clk)
	begin
		if (!reset_n)
			drive_level <= `DRIVE_NORMAL;
		else if (clk_en)
			drive_level <= drive_d;
	end

	always @(posedge core_clk)
	begin
		if (!reset_n)
			load_cap <= `CAP_7P0;
		else if (clk_en)
			load_cap <= cap_d;
	end

	// ----------------------------------------
	// Interrupt routing
	// ----------------------------------------
	// Source bits 6:0 line up with mask bits 6:0; bit 7 is pulse/level mode, kept elsewhere
	wire [6:0] hit_a;
	wire [6:0] hit_b;
	genvar g;

	generate
		for (g = 0; g < 7; g = g + 1)
		begin : route
			assign hit_a[g] = src_q[g] & pin_a_irq_mask_q[g];
			assign hit_b[g] = src_q[g] & pin_b_irq_mask_q[g];
		end
	endgenerate

	// Pins are routed independently; one source may drive both at once
	always @(posedge core_clk)
	begin
		if (!reset_n)
			irq_a <= 1'b0;
		else if (clk_en)
			irq_a <= |hit_a;
	end

	always @(posedge core_clk)
	begin
		if (!reset_n)
			irq_b <= 1'b0;
		else if (clk_en)
			irq_b <= |hit_b;
	end

endmodule

// ### tb/osc_ctrl_sva.sv
// Assertions on the oscillator control register ports
`timescale 1ns/1ns
module osc_ctrl_sva(
	input wire core_clk, reset_n, clk_en, reg_wr, reg_rd, stopwatch_mode,
	input wire [7:0] reg_addr, reg_wdata, clkout_taps, reg_rdata,
	input wire [6:0] irq_sources,
	input wire clk_out, low_jitter_rise, low_jitter_fall, offset_mode, twelve_hour,
	input wire [1:0] drive_level, load_cap,
	input wire irq_a, irq_b
);
default clocking @(posedge core_clk); endclocking
default disable iff (!reset_n);
wire rd25 = clk_en && reg_rd && reg_addr == 8'h25;
wire wr25 = clk_en && reg_wr && reg_addr == 8'h25;
a_reset_quiet: assert property (disable iff (1'b0) !reset_n |=> reg_rdata == 8'h00 && !irq_a)
	else $error("reset");
a_read_fields: assert property (rd25 |=> reg_rdata[6] == offset_mode)
	else $error("read");
a_read_unmap: assert property (clk_en && reg_rd && reg_addr > 8'h2A |=> reg_rdata == 8'h00)
	else $error("unmapped");
a_write_cap: assert property (wr25 ##1 clk_en |=> load_cap[1] == $past(reg_wdata[1], 2))
	else $error("cap");
a_jitter_excl: assert property (!(low_jitter_rise && low_jitter_fall))
	else $error("jitter");
a_drive_code: assert property (drive_level != 2'h3)
	else $error("drive");
a_sw_ignore: assert property ((stopwatch_mode && clk_en)[*5] |-> !twelve_hour)
	else $error("hour");
a_irq_idle: assert property ((clk_en && irq_sources == 7'h00)[*5] |-> !irq_a && !irq_b)
	else $error("irq");
cover property (wr25);
cover property (irq_a);
cover property (clk_out && low_jitter_fall);
endmodule
bind osc_ctrl_regs osc_ctrl_sva osc_ctrl_sva_i(.*);

// ### tb/tb.sv
// Self-checking bench for the oscillator control register block
`timescale 1ns/1ns
module tb;
reg core_clk = 0, reset_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, stopwatch_mode = 0;
reg [7:0] reg_addr = '0, reg_wdata = '0, clkout_taps = '0, d, f, ma, mb, a;
reg [6:0] irq_sources = '0;
wire [7:0] reg_rdata;
wire clk_out, low_jitter_rise, low_jitter_fall, offset_mode, twelve_hour, irq_a, irq_b;
wire [1:0] drive_level, load_cap;
int fail_count = 0, n_compared = 0, seed = 32'hE73C, m[256];
osc_ctrl_regs osc_ctrl_regs_i(.*);
initial forever #4 core_clk = ~core_clk;
task chk(input string n, input [10:0] s, e);
	n_compared++;
	if (s !== e)
	begin
		fail_count++;
		$display("BAD %s exp %h got %h", n, e, s);
	end
endtask
task wr(input [7:0] ad, dt);
	@(negedge core_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, ad, dt};
	@(negedge core_clk) reg_wr = 0;
	if (ad == 8'h25 || ad > 8'h27 && ad < 8'h2B) m[ad] = dt;
endtask
task rd(input [7:0] ad);
	@(negedge core_clk) {reg_rd, reg_addr} = {1'b1, ad};
	@(negedge core_clk) reg_rd = 0;
	chk("rd", reg_rdata, m[ad]);
endtask
task report_and_stop;
	$display("compared %0d bad %0d", n_compared, fail_count);
	if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
	else $display("RESULT: FAIL");
	$finish;
endtask
initial
begin
	#50000 fail_count++;
	report_and_stop;
end
initial
begin
	repeat (5) @(negedge core_clk);
	reset_n = 1;
	for (int i = 37; i < 43; i++) rd(i);
	for (int i = 0; i < 16; i++)
	begin
		a = $random(seed);
		stopwatch_mode = $random(seed);
		clkout_taps = $random(seed);
		irq_sources = i[0] ? $random(seed) : 7'h00;
		wr(a, 8'h5A);
		rd(a);
		d = $random(seed);
		d[3:0] = {i[1:0], i[3:2]};
		f = $random(seed);
		ma = $random(seed);
		mb = $random(seed);
		wr(8'h28, f);
		wr(8'h29, ma);
		wr(8'h2A, mb);
		wr(8'h25, d);
		rd(8'h25);
		chk("out", {clk_out, irq_a, irq_b, offset_mode, low_jitter_rise, low_jitter_fall,
			twelve_hour, drive_level, load_cap}, {clkout_taps[f[2:0]] ^ d[7],
			|(irq_sources & ma[6:0]), |(irq_sources & mb[6:0]), d[6], d[4] & ~d[7],
			d[4] & d[7], d[5] & ~stopwatch_mode, d[3] ? 2'h2 : {1'b0, d[2]},
			d[1] ? 2'h2 : {1'b0, d[0]}});
		$display("test %0d done", i);
	end
	wr(8'h25, 8'h00);
	rd(8'h25);
	chk("cap", load_cap, 2'h0);
	@(negedge core_clk) {clk_en, reg_wr, reg_addr, reg_wdata} = {1'b0, 1'b1, 8'h25, 8'hFF};
	@(negedge core_clk) {clk_en, reg_wr} = 2'b10;
	rd(8'h25);
	$display("test freeze done");
	wr(8'h28, 8'hA5);
	@(negedge core_clk) reset_n = 0;
	@(negedge core_clk) reset_n = 1;
	for (int i = 37; i < 43; i++) m[i] = 0;
	for (int i = 37; i < 43; i++) rd(i);
	$display("test reset done");
	report_and_stop;
end
endmodule
